//--- core/dem_pkg.sv
package dem_pkg;
  // beat geometry
  localparam int BEAT_W = 64;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  // register map (wishbone byte addresses)
  localparam logic [3:0] FMT_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_OFFSET = 4'h4;
  localparam logic [3:0] STAT_OFFSET = 4'h8;
  // data_format_select fields
  localparam int FMT_INDEX_BIT = 0;
  localparam int FMT_EXTR_BIT = 1;
  localparam logic [1:0] FMT_RESET = 2'h0;
  // control register fields
  localparam int CTRL_LITTLE_BIT = 0;
  localparam int CTRL_REVERSE_BIT = 1;
  localparam int CTRL_KIND_LSB = 4;
  localparam logic [1:0] CTRL_RESET_LITTLE = 2'h1;
  localparam logic [1:0] KIND_RESET = 2'h0;
  // beat kinds on the stream
  localparam logic [1:0] KIND_GENERIC = 2'h0;
  localparam logic [1:0] KIND_DECISION = 2'h1;
  localparam logic [1:0] KIND_INDEX = 2'h2;
  localparam logic [1:0] KIND_EXTR = 2'h3;
  localparam int BUF_DEPTH = 2;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

//--- core/dem_buffer.sv
`timescale 1ns/100ps
module dem_buffer #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // one-bit pointers only serve two entries
  if (DEPTH != 2) begin : g_bad_depth
    $error("dem_buffer supports depth 2 only");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("dem_buffer needs a width of at least one bit");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end
endmodule

//--- core/dem_manager.sv
// Functional notes
// - decisions travel as 32-bit words, first word at base, second at base+4.
// - reversed decision order in little-endian mirrors all 64 bits of an outgoing beat.
// - big-endian host order swaps the two decision words of an outgoing beat.
// - format register bit 0 is index format, bit 1 extrinsic, rest reserved.
// - indexes are 16-bit items; index bit 1 native, 0 packed on words.
// - extrinsics are 8-bit items; extrinsic bit 1 native, 0 packed on words.
// - little-endian host order passes indexes and extrinsics unchanged.
// - big-endian packed indexes map half-words 1,0,3,2 to 3,2,1,0.
// - big-endian native indexes fully reverse the four half-words of an incoming beat; outgoing index beats get the word swap.
// - big-endian packed extrinsics swap the two 32-bit halves.
// - big-endian native extrinsics fully reverse the eight bytes.
// - big-endian order swaps the words of all remaining 64-bit beats.
// - 32-bit register bus transfers are never byte reordered.
// - the core side always sees little-endian data.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module dem_manager (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dma_in_valid,
  output logic dma_in_ready,
  input wire logic [63:0] dma_in_data,
  output logic core_in_valid,
  input wire logic core_in_ready,
  output logic [63:0] core_in_data,
  input wire logic core_out_valid,
  output logic core_out_ready,
  input wire logic [63:0] core_out_data,
  output logic dma_out_valid,
  input wire logic dma_out_ready,
  output logic [63:0] dma_out_data
);
  localparam int BW = dem_pkg::BEAT_W;
  localparam int WW = dem_pkg::WORD_W;
  localparam int HW = dem_pkg::HALF_W;
  localparam int YW = dem_pkg::BYTE_W;

  // register state
  logic [1:0] data_format_select;
  logic host_little;
  logic decision_reverse;
  logic [1:0] in_kind;
  logic [1:0] out_kind;
  logic [15:0] in_beats;
  logic [15:0] out_beats;
  logic wb_req;
  logic [31:0] next_rdata;

  // reordered beats
  logic [63:0] in_swapped;
  logic [63:0] out_swapped;
  logic [63:0] word_swap_in;
  logic [63:0] half_rev_in;
  logic [63:0] half_pair_in;
  logic [63:0] byte_rev_in;
  logic [63:0] word_swap_out;
  logic [63:0] byte_rev_out;
  logic [63:0] bit_rev_out;

  // ---------------- wishbone slave ----------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // byte lane 0 holds every writable field, so only sel[0] matters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_format_select <= dem_pkg::FMT_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == dem_pkg::FMT_OFFSET) begin
      data_format_select <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_little <= dem_pkg::CTRL_RESET_LITTLE[0];
      decision_reverse <= dem_pkg::CTRL_RESET_LITTLE[1];
      in_kind <= dem_pkg::KIND_RESET;
      out_kind <= dem_pkg::KIND_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == dem_pkg::CTRL_OFFSET) begin
      host_little <= wb_dat_i[dem_pkg::CTRL_LITTLE_BIT];
      decision_reverse <= wb_dat_i[dem_pkg::CTRL_REVERSE_BIT];
      in_kind <= wb_dat_i[dem_pkg::CTRL_KIND_LSB +: 2];
      out_kind <= wb_dat_i[dem_pkg::CTRL_KIND_LSB + 2 +: 2];
    end
  end

  // register contents go out untouched: no lane swap on this bus
  always_comb begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      dem_pkg::FMT_OFFSET: next_rdata = {30'h0, data_format_select};
      dem_pkg::CTRL_OFFSET: next_rdata = {24'h0, out_kind, in_kind,
                                          2'h0, decision_reverse,
                                          host_little};
      dem_pkg::STAT_OFFSET: next_rdata = {out_beats, in_beats};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // beat counters show the stream is moving; they wrap silently
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_beats <= dem_pkg::CNT_RESET;
      out_beats <= dem_pkg::CNT_RESET;
    end else begin
      if (core_in_valid && core_in_ready) in_beats <= in_beats + 16'h0001;
      if (dma_out_valid && dma_out_ready) out_beats <= out_beats + 16'h0001;
    end
  end

  // ---------------- lane permutations ----------------
  assign word_swap_in = {dma_in_data[WW-1:0], dma_in_data[BW-1:WW]};
  assign word_swap_out = {core_out_data[WW-1:0], core_out_data[BW-1:WW]};

  // packed indexes: dma order 1,0,3,2 becomes core order 3,2,1,0
  assign half_pair_in = word_swap_in;

  genvar g;
  generate
    for (g = 0; g < BW / HW; g++) begin : g_half
      assign half_rev_in[g*HW +: HW] = dma_in_data[BW-(g+1)*HW +: HW];
    end
    for (g = 0; g < BW / YW; g++) begin : g_byte
      assign byte_rev_in[g*YW +: YW] = dma_in_data[BW-(g+1)*YW +: YW];
      assign byte_rev_out[g*YW +: YW] = core_out_data[BW-(g+1)*YW +: YW];
    end
    for (g = 0; g < BW; g++) begin : g_bit
      assign bit_rev_out[g] = core_out_data[BW-1-g];
    end
  endgenerate

  // incoming beats toward the core
  always_comb begin
    in_swapped = dma_in_data;
    if (!host_little) begin
      case (in_kind)
        dem_pkg::KIND_INDEX:
          in_swapped = data_format_select[dem_pkg::FMT_INDEX_BIT] ?
                       half_rev_in : half_pair_in;
        dem_pkg::KIND_EXTR:
          in_swapped = data_format_select[dem_pkg::FMT_EXTR_BIT] ?
                       byte_rev_in : word_swap_in;
        default: in_swapped = word_swap_in;
      endcase
    end else begin
      in_swapped = dma_in_data;
    end
  end

  // outgoing beats toward the dma; core words are always little-endian
  always_comb begin
    out_swapped = core_out_data;
    if (!host_little) begin
      case (out_kind)
        dem_pkg::KIND_DECISION: out_swapped = word_swap_out;
        dem_pkg::KIND_EXTR:
          out_swapped = data_format_select[dem_pkg::FMT_EXTR_BIT] ?
                        byte_rev_out : word_swap_out;
        default: out_swapped = word_swap_out;
      endcase
    end else if (out_kind == dem_pkg::KIND_DECISION && decision_reverse) begin
      out_swapped = bit_rev_out;
    end else begin
      out_swapped = core_out_data;
    end
  end

  // ---------------- buffers ----------------
  // swap happens before the buffer so a mode change mid-stall
  // cannot alter a word already accepted
  dem_buffer #(
    .WIDTH(BW),
    .DEPTH(dem_pkg::BUF_DEPTH)
  ) u_in_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(dma_in_valid),
    .in_ready(dma_in_ready),
    .in_data(in_swapped),
    .out_valid(core_in_valid),
    .out_ready(core_in_ready),
    .out_data(core_in_data)
  );

  dem_buffer #(
    .WIDTH(BW),
    .DEPTH(dem_pkg::BUF_DEPTH)
  ) u_out_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(core_out_valid),
    .in_ready(core_out_ready),
    .in_data(out_swapped),
    .out_valid(dma_out_valid),
    .out_ready(dma_out_ready),
    .out_data(dma_out_data)
  );
endmodule

//--- tb/dem_manager_chk.sv
`timescale 1ns/100ps
module dem_manager_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic dma_in_valid,
  input wire logic dma_in_ready,
  input wire logic core_in_valid,
  input wire logic core_in_ready,
  input wire logic [63:0] core_in_data,
  input wire logic core_out_valid,
  input wire logic core_out_ready,
  input wire logic dma_out_valid,
  input wire logic dma_out_ready,
  input wire logic [63:0] dma_out_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] held;
  // beats in the input buffer, counted from both handshakes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      held <= 2'h0;
    end else begin
      held <= held + 2'(dma_in_valid && dma_in_ready)
        - 2'(core_in_valid && core_in_ready);
    end
  end
  ack_latency_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  in_refuse_a: assert property (
    dma_in_ready == (held != 2'h2)) else $error("in ready wrong");
  in_valid_a: assert property (
    core_in_valid == (held != 2'h0)) else $error("core valid wrong");
  in_hold_a: assert property (
    core_in_valid && !core_in_ready |=> $stable(core_in_data))
    else $error("core data moved");
  out_hold_a: assert property (
    dma_out_valid && !dma_out_ready |=> dma_out_valid && $stable(dma_out_data))
    else $error("dma beat dropped");
  out_latency_a: assert property (
    core_out_valid && core_out_ready && !dma_out_valid |=> dma_out_valid)
    else $error("dma valid late");
  out_stall_a: assert property (
    !core_out_ready && !dma_out_ready |=> !core_out_ready)
    else $error("full buffer took");
  cover property (dma_in_valid && !dma_in_ready);
  cover property (dma_out_valid && !dma_out_ready);
  cover property (wb_ack_o);
endmodule

//--- tb/dem_dma_model.sv
`timescale 1ns/100ps
module dem_dma_model (
  input wire logic ref_clk,
  output logic in_valid,
  input wire logic in_ready,
  output logic [63:0] in_data,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [63:0] out_data
);
  int hung = 0;
  initial begin
    in_valid = 1'h0;
    in_data = 64'h0;
    out_ready = 1'h0;
  end
  // always whole 64-bit beats, native or packed alike
  task automatic send(input logic [63:0] d);
    @(posedge ref_clk);
    in_valid <= 1'h1;
    in_data <= d;
    for (int n = 0; n < 20 && in_ready !== 1'h1; n++) @(negedge ref_clk);
    hung += int'(in_ready !== 1'h1);
    @(posedge ref_clk);
    in_valid <= 1'h0;
    in_data <= ~d; // no stale copy once released
  endtask
  task automatic recv(output logic [63:0] d);
    @(posedge ref_clk);
    out_ready <= 1'h1;
    @(negedge ref_clk);
    for (int n = 0; n < 20 && out_valid !== 1'h1; n++) @(negedge ref_clk);
    hung += int'(out_valid !== 1'h1);
    d = out_data;
    @(posedge ref_clk);
    out_ready <= 1'h0;
  endtask
endmodule

//--- tb/test_decoder_endian_manager.sv
`timescale 1ns/100ps
module test_decoder_endian_manager;
  localparam logic [63:0] D = 64'h0123456789ABCDEF;
  localparam logic [63:0] W = 64'h89ABCDEF01234567;
  localparam logic [63:0] H = 64'hCDEF89AB45670123;
  localparam logic [63:0] B = 64'hEFCDAB8967452301;
  logic ref_clk = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic wb_ack_o, dma_in_valid, dma_in_ready, core_in_valid, core_out_ready;
  logic core_in_ready = 1'h0, core_out_valid = 1'h0;
  logic dma_out_valid, dma_out_ready;
  logic [63:0] dma_in_data, core_in_data, dma_out_data, g;
  logic [63:0] core_out_data = 64'h0;
  int fails = 0, total_checks = 0;
  dem_manager i_dut (.*);
  dem_dma_model i_dma (.ref_clk, .in_valid(dma_in_valid),
    .in_ready(dma_in_ready), .in_data(dma_in_data), .out_valid(dma_out_valid),
    .out_ready(dma_out_ready), .out_data(dma_out_data));
  initial forever #10 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] e, v);
    total_checks++;
    if (v !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, v);
    end
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? wb_ack_o : k == 1 ? core_in_valid : core_out_ready;
  endfunction
  // waits to the accepting edge; read values are taken just before it
  task automatic hold(input int k);
    for (int n = 0; n < 20 && sig(k) !== 1'h1; n++) @(negedge ref_clk);
    if (sig(k) !== 1'h1) begin
      fails++;
      tally_and_finish();
    end
    r = wb_dat_o;
    g = core_in_data;
    @(posedge ref_clk);
  endtask
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(negedge ref_clk);
    hold(0);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk("reg", 64'(e), 64'(r));
  endtask
  task automatic take(input logic [63:0] e);
    @(posedge ref_clk);
    core_in_ready <= 1'h1;
    @(negedge ref_clk);
    hold(1);
    core_in_ready <= 1'h0;
    chk("core_in", e, g);
  endtask
  task automatic give(input logic [63:0] d);
    @(posedge ref_clk);
    core_out_valid <= 1'h1;
    core_out_data <= d;
    @(negedge ref_clk);
    hold(2);
    core_out_valid <= 1'h0;
    core_out_data <= ~d;
  endtask
  task automatic run(input logic o, input logic [7:0] f, c,
                     input logic [63:0] e);
    bus(1'h1, 4'h0, 32'(f));
    bus(1'h1, 4'h4, 32'(c));
    if (o) begin
      give(D);
      i_dma.recv(g);
      chk("dma_out", e, g);
    end else begin
      i_dma.send(D);
      take(e);
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h1);
    rd(4'hC, 32'h0);
    bus(1'h1, 4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h3);
    run(0, 8'h3, 8'h21, D);
    run(0, 8'h3, 8'h31, D);
    run(0, 8'h0, 8'h00, W);
    run(0, 8'h0, 8'h20, W);
    run(0, 8'h1, 8'h20, H);
    run(0, 8'h0, 8'h30, W);
    run(0, 8'h2, 8'h30, B);
    run(1, 8'h0, 8'h00, W);
    run(1, 8'h0, 8'h40, W);
    run(1, 8'h0, 8'h43, 64'hF7B3D591E6A2C480);
    run(1, 8'h0, 8'h41, D);
    run(1, 8'h2, 8'hC0, B);
    run(1, 8'h0, 8'hC0, W);
    bus(1'h1, 4'h4, 32'h1);
    i_dma.send(D);
    i_dma.send(~D);
    @(negedge ref_clk);
    chk("in_ready", 64'h0, 64'(dma_in_ready));
    take(D);
    take(~D);
    give(W);
    give(H);
    @(negedge ref_clk);
    chk("out_ready", 64'h0, 64'(core_out_ready));
    i_dma.recv(g);
    chk("dma_out", W, g);
    i_dma.recv(g);
    chk("dma_out", H, g);
    rd(4'h8, 32'h00080009);
    chk("dma_hung", 64'h0, 64'(i_dma.hung));
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule
bind dem_manager dem_manager_chk u_chk (.ref_clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .dma_in_valid, .dma_in_ready, .core_in_valid,
  .core_in_ready, .core_in_data, .core_out_valid, .core_out_ready,
  .dma_out_valid, .dma_out_ready, .dma_out_data);
